// ==== rtl/ald_defs.svh ====
// Register map, field positions, reset values and cycle counts of the level detect and offset nulling block.
// Included by the package, the top module and the testbench; holds definitions only.
`ifndef ALD_DEFS_SVH
`define ALD_DEFS_SVH
`define ALD_A_CHIDX 13'h0005
`define ALD_A_FMT 13'h0014
`define ALD_A_DCC 13'h0040
`define ALD_A_OFS_LO 13'h0041
`define ALD_A_OFS_HI 13'h0042
`define ALD_A_FD 13'h0045
`define ALD_A_UP_LO 13'h0047
`define ALD_A_UP_HI 13'h0048
`define ALD_A_LO_LO 13'h0049
`define ALD_A_LO_HI 13'h004A
`define ALD_A_DW_LO 13'h004B
`define ALD_A_DW_HI 13'h004C
`define ALD_ADDR_STEP 13'h0001
`define ALD_FD_EN 0
`define ALD_DCC_EN 1
`define ALD_DCC_K_LSB 2
`define ALD_DCC_FRZ 6
`define ALD_CHIDX_A 0
`define ALD_CHIDX_B 1
`define ALD_INSTR_RD 15
`define ALD_FMT_OFFBIN 2'h0
`define ALD_RST_FMT 8'h01
`define ALD_RST_CHIDX 8'h03
`define ALD_RST_DW_LO 8'h01
`define ALD_OVR_LAT 36
`define ALD_SMP_W 11
`define ALD_MAG_SH 5
`define ALD_ACC_W 44
`define ALD_DCC_FRAC 28
`define ALD_DCC_KBASE 5'h0E
`define ALD_FIFO_DEPTH 8
`define ALD_INSTR_LAST 4'hF
`define ALD_BYTE_LAST 3'h7
`endif

// ==== rtl/ald_pkg.sv ====
// Types shared by the level detect block: serial port states and the state records.
// Assumes ald_defs.svh is on the include path.
`include "ald_defs.svh"
package ald_pkg;
  typedef enum logic [1:0] {
    ALD_SP_IDLE = 2'b00,
    ALD_SP_INSTR = 2'b01,
    ALD_SP_DATA = 2'b10
  } ald_spi_st_t;

  // Per-channel pipeline, alert, dwell and offset estimate.
  typedef struct packed {
    logic [15:0] mag1;
    logic [15:0] x1;
    logic above2;
    logic below2;
    logic above3;
    logic below3;
    logic alert;
    logic [15:0] cnt;
    logic [`ALD_ACC_W-1:0] acc;
    logic [`ALD_SMP_W-1:0] dout;
  } ald_chan_t;

  typedef struct packed {
    logic sclk_m, sclk_s, sclk_p, csb_m, csb_s, sdi_m, sdi_s;
    ald_spi_st_t st;
    logic [3:0] bitn;
    logic [15:0] instr;
    logic rd;
    logic [12:0] addr;
    logic [7:0] shin, shout;
    logic sdo, oe;
    logic [7:0] fmt, chidx, dcc, fd, up_lo, up_hi, lo_lo, lo_hi, dw_lo, dw_hi;
    logic [1:0] vld;
    ald_chan_t [1:0] ch;
  } ald_top_t;
endpackage

// ==== rtl/ald_strm_if.sv ====
// Valid/ready word stream between the sample path and the output buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface ald_strm_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/ald_dly.sv ====
// Fixed delay line for a one-bit flag, used to match the converter pipeline.
// Assumes din is synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module ald_dly #(parameter int N = 36) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);
  typedef struct packed {logic [N-1:0] sr;} ald_dly_t;
  ald_dly_t q, d;

  // Each clock moves the flag one stage on.
  always_comb begin
    d = q;
    d.sr = {q.sr[N-2:0], din};
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.sr[N-1];
endmodule
`default_nettype wire

// ==== rtl/ald_fifo.sv ====
// Flip-flop FIFO of DEPTH words, valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/10ps
`default_nettype none
module ald_fifo #(parameter int W = 22, parameter int DEPTH = 8) (
  input wire logic clk,
  input wire logic rstn,
  ald_strm_if.snk in_s,
  ald_strm_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp, rp;
  } ald_fifo_t;
  ald_fifo_t q, d;
  logic full, empty;

  // The extra pointer bit tells a full buffer from an empty one.
  assign empty = (q.wp == q.rp);
  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = q.mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (in_s.valid && !full) begin
      d.mem[q.wp[AW-1:0]] = in_s.data;
      d.wp = q.wp + 1'b1;
    end
    if (out_s.ready && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ald_top.sv ====
// Level detect and offset nulling for two converter channels, with its serial register port.
// Samples, overrange flags and sample valid arrive on clk; the serial port pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "ald_defs.svh"
module ald_top
  import ald_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`ALD_SMP_W-1:0] adc_a_data,
  input wire logic [`ALD_SMP_W-1:0] adc_b_data,
  input wire logic adc_a_ovr,
  input wire logic adc_b_ovr,
  input wire logic adc_valid,
  output logic adc_sample_ready,
  output logic overrange_a,
  output logic overrange_b,
  output logic level_alert_chan_a,
  output logic level_alert_chan_b,
  output logic [2*`ALD_SMP_W-1:0] link_data,
  output logic link_valid,
  input wire logic link_ready,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe
);
  ald_top_t q, d;
  ald_chan_t ch_nxt [2];
  logic [`ALD_SMP_W-1:0] smp [2];
  logic rise, fall;
  logic [7:0] wbyte;
  logic fd_en, dcc_en, dcc_frz, offbin;
  logic [3:0] dcc_k;
  logic [15:0] up_thr, lo_thr, dwell, ofs_rb;

  ald_strm_if #(.W(2*`ALD_SMP_W)) fin ();
  ald_strm_if #(.W(2*`ALD_SMP_W)) fout ();

  assign smp[0] = adc_a_data;
  assign smp[1] = adc_b_data;

  // Configuration fields as the datapath sees them.
  assign fd_en = q.fd[`ALD_FD_EN];
  assign up_thr = {q.up_hi, q.up_lo};
  assign lo_thr = {q.lo_hi, q.lo_lo};
  assign dwell = {q.dw_hi, q.dw_lo};
  assign dcc_k = q.dcc[`ALD_DCC_K_LSB+3:`ALD_DCC_K_LSB];
  assign dcc_frz = q.dcc[`ALD_DCC_FRZ];
  assign dcc_en = q.dcc[`ALD_DCC_EN];
  assign offbin = (q.fmt[1:0] == `ALD_FMT_OFFBIN);

  // Readback follows channel B only when B alone is selected, otherwise channel A.
  assign ofs_rb = (q.chidx[`ALD_CHIDX_B] && !q.chidx[`ALD_CHIDX_A]) ?
                  q.ch[1].acc[`ALD_ACC_W-1 -: 16] : q.ch[0].acc[`ALD_ACC_W-1 -: 16];

  // Edges are taken from the second and third stages; the first stage feeds nothing else.
  assign rise = q.sclk_s && !q.sclk_p;
  assign fall = !q.sclk_s && q.sclk_p;
  assign wbyte = {q.shin[6:0], q.sdi_s};

  // Register read mux; unmapped addresses read as zero.
  function automatic logic [7:0] rd_byte(input logic [12:0] a, input ald_top_t s, input logic [15:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ALD_A_CHIDX: v = s.chidx;
      `ALD_A_FMT: v = s.fmt;
      `ALD_A_DCC: v = s.dcc;
      `ALD_A_OFS_LO: v = ofs[7:0];
      `ALD_A_OFS_HI: v = ofs[15:8];
      `ALD_A_FD: v = s.fd;
      `ALD_A_UP_LO: v = s.up_lo;
      `ALD_A_UP_HI: v = s.up_hi;
      `ALD_A_LO_LO: v = s.lo_lo;
      `ALD_A_LO_HI: v = s.lo_hi;
      `ALD_A_DW_LO: v = s.dw_lo;
      `ALD_A_DW_HI: v = s.dw_hi;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Serial port, register writes and the sample valid pipe.
  always_comb begin
    d = q;
    d.sclk_m = sclk;
    d.sclk_s = q.sclk_m;
    d.sclk_p = q.sclk_s;
    d.csb_m = csb_n;
    d.csb_s = q.csb_m;
    d.sdi_m = sdio_in;
    d.sdi_s = q.sdi_m;
    d.vld = {q.vld[0], adc_valid};
    d.ch[0] = ch_nxt[0];
    d.ch[1] = ch_nxt[1];
    if (q.csb_s) begin
      // Chip select high ends any frame and releases the data pin.
      d.st = ALD_SP_IDLE;
      d.oe = 1'b0;
      d.bitn = '0;
    end else begin
      unique case (q.st)
        ALD_SP_IDLE: begin
          d.st = ALD_SP_INSTR;
          d.bitn = '0;
        end
        ALD_SP_INSTR: begin
          if (rise) begin
            d.instr = {q.instr[14:0], q.sdi_s};
            d.bitn = q.bitn + 4'h1;
            if (q.bitn == `ALD_INSTR_LAST) begin
              d.st = ALD_SP_DATA;
              d.bitn = '0;
              d.rd = d.instr[`ALD_INSTR_RD];
              d.addr = d.instr[12:0];
              d.shout = rd_byte(d.instr[12:0], q, ofs_rb);
            end
          end
        end
        ALD_SP_DATA: begin
          if (rise) begin
            d.shin = wbyte;
            d.bitn = q.bitn + 4'h1;
            if (q.bitn[2:0] == `ALD_BYTE_LAST) begin
              // Streaming walks down the address map one byte at a time.
              d.bitn = '0;
              d.addr = q.addr - `ALD_ADDR_STEP;
              d.shout = rd_byte(q.addr - `ALD_ADDR_STEP, q, ofs_rb);
              if (!q.rd) begin
                case (q.addr)
                  `ALD_A_CHIDX: d.chidx = wbyte;
                  `ALD_A_FMT: d.fmt = wbyte;
                  `ALD_A_DCC: d.dcc = wbyte;
                  `ALD_A_FD: d.fd = wbyte;
                  `ALD_A_UP_LO: d.up_lo = wbyte;
                  `ALD_A_UP_HI: d.up_hi = wbyte;
                  `ALD_A_LO_LO: d.lo_lo = wbyte;
                  `ALD_A_LO_HI: d.lo_hi = wbyte;
                  `ALD_A_DW_LO: d.dw_lo = wbyte;
                  `ALD_A_DW_HI: d.dw_hi = wbyte;
                  default: d.addr = q.addr - `ALD_ADDR_STEP;
                endcase
              end
            end
          end
          if (fall && q.rd) begin
            // Read data changes on the falling edge so the master samples it on the rise.
            d.oe = 1'b1;
            d.sdo = q.shout[7];
            d.shout = {q.shout[6:0], 1'b0};
          end
        end
        default: d.st = ALD_SP_IDLE;
      endcase
    end
  end

  // One state record for the block apart from the output buffer and overrange delays, reset synchronously.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
      q.csb_m <= 1'b1;
      q.csb_s <= 1'b1;
      q.fmt <= `ALD_RST_FMT;
      q.chidx <= `ALD_RST_CHIDX;
      q.dw_lo <= `ALD_RST_DW_LO;
    end else begin
      q <= d;
    end
  end

  // Per-channel detector and offset nulling; the two channels share settings but not state.
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [`ALD_SMP_W-1:0] mag_abs;
    logic [15:0] mag_in;
    logic ovr_in;
    logic ovr_out;

    // Sign is dropped here; the most negative code maps to a magnitude of 1024.
    assign mag_abs = smp[i][`ALD_SMP_W-1] ? (~smp[i] + 1'b1) : smp[i];
    assign mag_in = {mag_abs, {`ALD_MAG_SH{1'b0}}};
    assign ovr_in = (i == 0) ? adc_a_ovr : adc_b_ovr;

    always_comb begin
      logic signed [`ALD_ACC_W:0] err;
      logic [16:0] diff;
      logic [15:0] sat;
      logic [`ALD_SMP_W-1:0] y;
      err = '0;
      diff = '0;
      sat = '0;
      y = '0;
      ch_nxt[i] = q.ch[i];
      // Four stages from sample to alert: magnitude, compare, align, decide.
      ch_nxt[i].mag1 = mag_in;
      ch_nxt[i].x1 = {smp[i], {`ALD_MAG_SH{1'b0}}};
      ch_nxt[i].above2 = q.ch[i].mag1 > up_thr;
      ch_nxt[i].below2 = q.ch[i].mag1 < lo_thr;
      ch_nxt[i].above3 = q.ch[i].above2;
      ch_nxt[i].below3 = q.ch[i].below2;
      if (!fd_en) begin
        ch_nxt[i].alert = 1'b0;
        ch_nxt[i].cnt = '0;
      end else if (q.ch[i].above3) begin
        ch_nxt[i].alert = 1'b1;
        ch_nxt[i].cnt = '0;
      end else if (q.ch[i].alert && q.ch[i].below3) begin
        // A dwell of zero behaves as one; software is expected to avoid it.
        if (({1'b0, q.ch[i].cnt} + 17'h00001) >= {1'b0, dwell}) begin
          ch_nxt[i].alert = 1'b0;
          ch_nxt[i].cnt = '0;
        end else begin
          ch_nxt[i].cnt = q.ch[i].cnt + 16'h0001;
        end
      end else begin
        ch_nxt[i].cnt = '0;
      end
      // Leaky integrator: the estimate moves by the error scaled down by 2^(k+14).
      if (!dcc_frz) begin
        err = $signed({q.ch[i].x1[15], q.ch[i].x1, {`ALD_DCC_FRAC{1'b0}}}) -
              $signed({q.ch[i].acc[`ALD_ACC_W-1], q.ch[i].acc});
        err = err >>> ({1'b0, dcc_k} + `ALD_DCC_KBASE);
        ch_nxt[i].acc = q.ch[i].acc + err[`ALD_ACC_W-1:0];
      end
      // Subtraction saturates so a large estimate cannot wrap the output.
      diff = {q.ch[i].x1[15], q.ch[i].x1};
      if (dcc_en) begin
        diff = diff - {q.ch[i].acc[`ALD_ACC_W-1], q.ch[i].acc[`ALD_ACC_W-1 -: 16]};
      end
      if (diff[16] != diff[15]) begin
        sat = diff[16] ? 16'h8000 : 16'h7FFF;
      end else begin
        sat = diff[15:0];
      end
      y = sat[15:`ALD_MAG_SH];
      if (offbin) begin
        y[`ALD_SMP_W-1] = ~y[`ALD_SMP_W-1];
      end
      ch_nxt[i].dout = y;
    end

    // Overrange is only delayed, never filtered, so it matches the sample latency.
    ald_dly #(.N(`ALD_OVR_LAT)) u_ovr (
      .clk(clk),
      .rstn(rstn),
      .din(ovr_in),
      .dout(ovr_out)
    );
    if (i == 0) begin : g_a
      assign overrange_a = ovr_out;
    end else begin : g_b
      assign overrange_b = ovr_out;
    end

    AST_UP_LAT: assert property (@(posedge clk) disable iff (!rstn)
      (fd_en && mag_in > up_thr) ##1 fd_en [*4] |-> q.ch[i].alert)
      else $error("alert not set four cycles after an upper crossing");
    AST_STAY_LOW: assert property (@(posedge clk) disable iff (!rstn)
      (!q.ch[i].alert && !q.ch[i].above3) |=> !q.ch[i].alert)
      else $error("alert rose without an upper crossing");
    AST_DWELL_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      (fd_en && q.ch[i].alert && ({1'b0, q.ch[i].cnt} + 17'h00001) < {1'b0, dwell}) |=> q.ch[i].alert)
      else $error("alert cleared before the dwell time ran out");
    AST_DWELL_RST: assert property (@(posedge clk) disable iff (!rstn)
      (fd_en && q.ch[i].alert && !q.ch[i].below3) |=> (q.ch[i].cnt == 16'h0000))
      else $error("dwell count not restarted at the lower threshold");
    AST_FREEZE: assert property (@(posedge clk) disable iff (!rstn)
      dcc_frz |=> (q.ch[i].acc == $past(q.ch[i].acc)))
      else $error("offset estimate moved while frozen");
    AST_BYPASS: assert property (@(posedge clk) disable iff (!rstn)
      (!dcc_en && !offbin) |=> (q.ch[i].dout == $past(q.ch[i].x1[15:`ALD_MAG_SH])))
      else $error("sample altered while nulling is off");
    AST_OFFBIN: assert property (@(posedge clk) disable iff (!rstn)
      (!dcc_en && offbin) |=> (q.ch[i].dout == {~$past(q.ch[i].x1[15]), $past(q.ch[i].x1[14:`ALD_MAG_SH])}))
      else $error("offset binary output not formed from the sample");
  end

  // Samples are written only when the buffer can take them; a stalled link drops samples.
  assign fin.valid = q.vld[1];
  assign fin.data = {q.ch[1].dout, q.ch[0].dout};
  assign adc_sample_ready = fin.ready;
  assign fout.ready = link_ready;
  assign link_valid = fout.valid;
  assign link_data = fout.data;

  ald_fifo #(.W(2*`ALD_SMP_W), .DEPTH(`ALD_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_s(fin.snk),
    .out_s(fout.src)
  );

  // Alert and serial data outputs come straight from flip-flops.
  assign level_alert_chan_a = q.ch[0].alert;
  assign level_alert_chan_b = q.ch[1].alert;
  assign sdio_out = q.sdo;
  assign sdio_oe = q.oe;

  AST_OVR_A: assert property (@(posedge clk) disable iff (!rstn)
    adc_a_ovr ##1 rstn [*8] |-> ##28 overrange_a)
    else $error("overrange A not shown 36 cycles after the sample");
  AST_OVR_B: assert property (@(posedge clk) disable iff (!rstn)
    !adc_b_ovr ##1 rstn [*8] |-> ##28 !overrange_b)
    else $error("overrange B shown without an overrange sample");
  AST_FD_OFF: assert property (@(posedge clk) disable iff (!rstn)
    (!fd_en) [*2] |-> (!level_alert_chan_a && !level_alert_chan_b))
    else $error("level alert active while detection is disabled");
endmodule
`default_nettype wire

// ==== tb/ald_link_sink.sv ====
// Downstream link model: takes formatted sample words off the block's output buffer.
// Assumes the block's clock; stall and slow pacing come from the testbench.
`timescale 1ns/10ps
`default_nettype none
module ald_link_sink (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [21:0] link_data,
  input wire logic link_valid,
  output logic link_ready,
  input wire logic stall,
  input wire logic slow,
  output logic [15:0] n_words,
  output logic [21:0] last_word
);
  logic tog_q;

  // A slow sink accepts only every other cycle, so the buffer backs up as it would downstream.
  assign link_ready = !stall && (!slow || tog_q);

  // Count and keep each word at the edge where valid and ready meet.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tog_q <= 1'b0;
      n_words <= 16'h0000;
      last_word <= 22'h000000;
    end else begin
      tog_q <= !tog_q;
      if (link_valid && link_ready) begin
        n_words <= n_words + 16'h0001;
        last_word <= link_data;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the level detect and offset nulling block.
// Assumes ald_defs.svh on the include path and the link sink model beside it.
`timescale 1ns/10ps
`default_nettype none
`include "ald_defs.svh"
module testbench;
  logic clk, rstn, adc_valid, adc_a_ovr, adc_b_ovr, sclk, csb_n, tb_sdio, tb_drv, stall, slow;
  logic [10:0] adc_a_data, adc_b_data;
  logic rdy, ovr_a, ovr_b, al_a, al_b, lvalid, lready, sdio_out, sdio_oe, sdio_w;
  logic [21:0] ldata, last_word;
  logic [15:0] n_words;
  int n_mismatch, cmp_count;

  // The data pin is shared: the block wins while it drives, otherwise the bench, else a pull-up.
  assign sdio_w = sdio_oe ? sdio_out : (tb_drv ? tb_sdio : 1'b1);

  ald_top u_dut (.clk(clk), .rstn(rstn), .adc_a_data(adc_a_data), .adc_b_data(adc_b_data),
    .adc_a_ovr(adc_a_ovr), .adc_b_ovr(adc_b_ovr), .adc_valid(adc_valid), .adc_sample_ready(rdy),
    .overrange_a(ovr_a), .overrange_b(ovr_b), .level_alert_chan_a(al_a), .level_alert_chan_b(al_b),
    .link_data(ldata), .link_valid(lvalid), .link_ready(lready), .sclk(sclk), .csb_n(csb_n),
    .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe));

  ald_link_sink u_sink (.clk(clk), .rstn(rstn), .link_data(ldata), .link_valid(lvalid),
    .link_ready(lready), .stall(stall), .slow(slow), .n_words(n_words), .last_word(last_word));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  task automatic check(input logic [21:0] got, input logic [21:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One serial bit: sclk half periods of 6 clocks keep well clear of the synchronisers and edge stage.
  task automatic spi_bit(input logic b, output logic r);
    tb_sdio <= b;
    sclk <= 1'b0;
    repeat (6) @(posedge clk);
    r = sdio_w;
    sclk <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [15:0] ins;
    logic r;
    ins = {rd, 2'b00, a};
    @(posedge clk);
    csb_n <= 1'b0;
    tb_drv <= 1'b1;
    for (int i = 15; i >= 0; i--) spi_bit(ins[i], r);
    tb_drv <= !rd;
    for (int i = 7; i >= 0; i--) begin
      spi_bit(wd[i], r);
      q[i] = r;
    end
    sclk <= 1'b0;
    repeat (6) @(posedge clk);
    // The block drives the data pin only during the data phase of a read.
    check(sdio_oe, rd, "data pin direction in frame");
    csb_n <= 1'b1;
    tb_drv <= 1'b0;
    repeat (8) @(posedge clk);
    check(sdio_oe, 1'b0, "data pin released after frame");
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [12:0] a, output logic [7:0] q);
    spi(1'b1, a, 8'h00, q);
  endtask

  task automatic rd_ofs(output logic [15:0] v);
    rd(`ALD_A_OFS_LO, v[7:0]);
    rd(`ALD_A_OFS_HI, v[15:8]);
  endtask

  // Reset values, an unmapped read, a read-only write, then the thresholds and dwell of 5.
  task automatic t_regs();
    logic [7:0] q;
    rd(`ALD_A_FMT, q); check(q, 8'h01, "format reset");
    rd(`ALD_A_DW_LO, q); check(q, 8'h01, "dwell reset");
    rd(`ALD_A_FD, q); check(q, 8'h00, "detect enable reset");
    rd(13'h0013, q); check(q, 8'h00, "unmapped read");
    wr(`ALD_A_OFS_LO, 8'hAA);
    rd(`ALD_A_OFS_LO, q); check(q, 8'h00, "offset is read only");
    wr(`ALD_A_UP_HI, 8'h10);
    rd(`ALD_A_UP_HI, q); check(q, 8'h10, "upper threshold readback");
    wr(`ALD_A_LO_HI, 8'h08);
    wr(`ALD_A_DW_LO, 8'h05);
  endtask

  // One-cycle sample on a channel, then back to zero.
  task automatic hit(input logic b, input logic [10:0] v);
    @(posedge clk);
    if (b) adc_b_data <= v;
    else adc_a_data <= v;
    @(posedge clk);
    adc_a_data <= 11'h000;
    adc_b_data <= 11'h000;
  endtask

  // Disabled detector ignores a big sample; enabled, a sample equal to the upper threshold is not an alert.
  task automatic t_quiet();
    hit(1'b0, 11'h081);
    repeat (8) @(posedge clk);
    #1 check(al_a, 1'b0, "alert while disabled");
    wr(`ALD_A_FD, 8'h01);
    hit(1'b0, 11'h080);
    repeat (8) @(posedge clk);
    #1 check(al_a, 1'b0, "alert at equal magnitude");
  endtask

  // Alert four cycles after the sample; a sample at the lower threshold restarts the dwell.
  task automatic t_alert();
    hit(1'b0, 11'h081);
    repeat (2) @(posedge clk);
    #1 check(al_a, 1'b0, "alert too early");
    @(posedge clk);
    adc_a_data <= 11'h040;
    #1 check(al_a, 1'b1, "alert set");
    check(al_b, 1'b0, "other channel quiet");
    @(posedge clk);
    adc_a_data <= 11'h000;
    repeat (7) @(posedge clk);
    #1 check(al_a, 1'b1, "alert held through dwell");
    @(posedge clk);
    #1 check(al_a, 1'b0, "alert cleared after dwell");
  endtask

  // A negative excursion on the second channel alerts that channel alone.
  task automatic t_chan_b();
    hit(1'b1, 11'h77F);
    repeat (2) @(posedge clk);
    #1 check(al_b, 1'b0, "channel b too early");
    @(posedge clk);
    #1 check(al_b, 1'b1, "negative sample alert");
    check(al_a, 1'b0, "channel a untouched");
    repeat (12) @(posedge clk);
  endtask

  task automatic t_ovr();
    @(posedge clk);
    adc_a_ovr <= 1'b1;
    @(posedge clk);
    adc_a_ovr <= 1'b0;
    repeat (34) @(posedge clk);
    #1 check(ovr_a, 1'b0, "overrange early");
    @(posedge clk);
    #1 check(ovr_a, 1'b1, "overrange at 36");
    check(ovr_b, 1'b0, "overrange b quiet");
    @(posedge clk);
    #1 check(ovr_a, 1'b0, "overrange one cycle");
  endtask

  // Offset tracking, freeze, correction of the output word, and resume.
  task automatic t_dcc();
    logic [15:0] o1, o2;
    logic [15:0] e;
    @(posedge clk);
    adc_a_data <= 11'h0C8;
    wr(`ALD_A_DCC, 8'h02);
    repeat (3000) @(posedge clk);
    rd_ofs(o1);
    check(o1 == 16'h0000, 1'b0, "offset estimate moves");
    wr(`ALD_A_DCC, 8'h42);
    rd_ofs(o1);
    repeat (1000) @(posedge clk);
    rd_ofs(o2);
    check(o2, o1, "frozen offset");
    e = 16'h1900 - o1;
    @(posedge clk);
    adc_valid <= 1'b1;
    @(posedge clk);
    adc_valid <= 1'b0;
    repeat (8) @(posedge clk);
    check(last_word[10:0], e[15:5], "corrected sample");
    wr(`ALD_A_DCC, 8'h02);
    repeat (2000) @(posedge clk);
    rd_ofs(o2);
    check(o2 == o1, 1'b0, "tracking resumed");
    wr(`ALD_A_DCC, 8'h00);
    adc_a_data <= 11'h000;
  endtask

  // Fill the buffer against a stalled sink, drain it slowly, then switch to offset binary.
  task automatic t_fifo();
    logic [15:0] n0;
    n0 = n_words;
    @(posedge clk);
    stall <= 1'b1;
    adc_a_data <= 11'h005;
    adc_b_data <= 11'h7FD;
    adc_valid <= 1'b1;
    repeat (12) @(posedge clk);
    adc_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(rdy, 1'b0, "buffer full");
    @(posedge clk);
    stall <= 1'b0;
    slow <= 1'b1;
    repeat (30) @(posedge clk);
    #1 check(n_words - n0, 16'h0008, "words drained");
    check(last_word, {11'h7FD, 11'h005}, "two's complement word");
    check({rdy, lvalid}, 2'b10, "buffer empty");
    wr(`ALD_A_FMT, 8'h00);
    @(posedge clk);
    adc_valid <= 1'b1;
    @(posedge clk);
    adc_valid <= 1'b0;
    repeat (8) @(posedge clk);
    check(last_word, {11'h3FD, 11'h405}, "offset binary word");
    slow <= 1'b0;
  endtask

  // Main sequence: 16 cycles of reset, then every scenario in turn.
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {adc_valid, adc_a_ovr, adc_b_ovr, sclk, tb_sdio, tb_drv, stall, slow} = 8'h00;
    csb_n = 1'b1;
    adc_a_data = 11'h000;
    adc_b_data = 11'h000;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_quiet();
    t_alert();
    t_chan_b();
    t_ovr();
    t_dcc();
    t_fifo();
    complete_run();
  end

  // The scenarios need about 13500 cycles; over four times that means a hang.
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
